/* File: logic/adc_timing_map.vh */
/*
 * Register map, field positions, reset values and timing counts of the
 * converter acquisition and bit-clock control block.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
 */
`ifndef ADC_TIMING_MAP_VH
`define ADC_TIMING_MAP_VH

// ==========================================================================
// Register offsets (byte addresses)
// ==========================================================================
`define REG_TIMING_CTRL 5'h00
`define REG_CONV_CTRL 5'h04
`define REG_TRIG_EN 5'h08
`define REG_STATUS 5'h0C
`define REG_RESULT 5'h10

// ==========================================================================
// Field positions
// ==========================================================================
`define CLKSEL_LSB 0
`define CLKSEL_MSB 2
`define ACQSEL_LSB 3
`define ACQSEL_MSB 6
`define CTRL_GO_BIT 0
`define CTRL_ENABLE_BIT 1
`define STAT_GO_BIT 0
`define STAT_ENABLE_BIT 1

// ==========================================================================
// Reset values
// ==========================================================================
`define TIMING_CTRL_RESET 7'h00
`define ENABLE_RESET 1'b0
`define TRIG_EN_RESET 5'h00

// ==========================================================================
// Timing counts
// ==========================================================================
`define CONV_BIT_PERIODS 5'h0C
`define RC_QUARTER_DIV 2'h3

`endif

/* File: logic/bit_period_gen.v */
/*
 * Conversion bit period generator: a one-cycle tick per bit period, taken
 * either from a programmable divider of the system clock or from the
 * internal RC oscillator, straight or divided by four.
 * Assumes i_rc_tick is a one-cycle pulse already synchronous to i_clk.
 */
`timescale 1ns/1ps
`include "adc_timing_map.vh"

module bit_period_gen #(
    parameter CNT_W = 6
) (
    input wire i_clk,
    input wire i_resetn,
    input wire i_restart,
    input wire [2:0] i_sel,
    input wire i_rc_tick,
    output reg o_tick
);

    // ======================================================================
    // Divider reload decode
    // ======================================================================
    // 000=2, 100=4, 001=8, 101=16, 010=32, 110=64 clocks; x11 is RC.
    wire [2:0] exp_w = {i_sel[1:0], 1'b0} + {2'b00, i_sel[2]} + 3'h1;
    wire [6:0] period_w = 7'h01 << exp_w;
    wire [CNT_W-1:0] reload_w = period_w[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
    wire use_rc_w = (i_sel[1:0] == 2'b11);

    reg [CNT_W-1:0] cnt_r;
    reg [1:0] rc_div_r;

    // ======================================================================
    // Divider
    // ======================================================================
    // Restart aligns the count so every divided-clock bit period that follows is whole.
    always @(posedge i_clk) begin
        if (!i_resetn || i_restart) begin
            cnt_r <= {CNT_W{1'b0}};
            rc_div_r <= 2'h0;
            o_tick <= 1'b0;
        end else if (use_rc_w) begin
            cnt_r <= {CNT_W{1'b0}};
            if (!i_rc_tick) begin
                o_tick <= 1'b0;
            end else if (i_sel[2]) begin
                o_tick <= 1'b1;
            end else begin
                rc_div_r <= rc_div_r + 2'h1;
                o_tick <= (rc_div_r == `RC_QUARTER_DIV);
            end
        end else if (cnt_r == reload_w) begin
            cnt_r <= {CNT_W{1'b0}};
            o_tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            o_tick <= 1'b0;
        end
    end

endmodule // bit_period_gen

/* File: logic/adc_acq_ctrl.v */
/*
 * Acquisition and conversion timing control of a 10-bit converter, with an
 * Avalon-MM register slave. It times programmed acquisition in bit periods,
 * disconnects the holding capacitor for twelve bit periods of conversion
 * and captures the core's result when the conversion ends.
 * Assumes trigger and RC tick inputs are synchronous one-cycle pulses and
 * that the analog core presents its result by the last bit period.
 */

`timescale 1ns/1ps
`include "adc_timing_map.vh"

module adc_acq_ctrl #(
    parameter TRIG_W = 5,
    parameter RES_W = 10
) (
    input wire i_clk,
    input wire i_resetn,
    input wire [4:0] i_address,
    input wire i_read,
    input wire i_write,
    input wire [31:0] i_writedata,
    output wire [31:0] o_readdata,
    output wire o_waitrequest,
    input wire [TRIG_W-1:0] i_trigger,
    input wire i_rc_tick,
    input wire [RES_W-1:0] i_core_result,
    output wire o_hold_connect,
    output wire o_conv_active,
    output wire o_bit_tick,
    output reg o_conv_done,
    output wire [RES_W-1:0] o_result
);

    // ======================================================================
    // States
    // ======================================================================
    localparam ST_IDLE = 3'b001;
    localparam ST_ACQ = 3'b010;
    localparam ST_CONV = 3'b100;

    // Acquisition length in bit periods: twice the code, so 0010 gives four.
    function [4:0] acq_periods;
        input [3:0] code;
        begin
            acq_periods = {code, 1'b0};
        end
    endfunction

    // True on the tick that completes a phase of len bit periods.
    function period_done;
        input [4:0] count;
        input [4:0] len;
        begin
            period_done = ((count + 5'h01) == len);
        end
    endfunction

    // Exact offset match, so no register aliases at an unused address.
    function addr_hit;
        input [4:0] addr;
        input [4:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    reg [2:0] st_r;
    reg [2:0] st_nxt;
    reg [4:0] cnt_r;
    reg [4:0] cnt_nxt;
    reg go_r;
    reg go_nxt;
    reg enable_r;
    reg [6:0] timing_r;
    reg [TRIG_W-1:0] trig_en_r;
    reg [RES_W-1:0] result_r;
    reg ack_r;
    reg [31:0] rdata_r;
    reg [31:0] rdata_nxt;

    wire tad_tick;
    wire [2:0] clk_sel = timing_r[`CLKSEL_MSB:`CLKSEL_LSB];
    wire [3:0] acq_sel = timing_r[`ACQSEL_MSB:`ACQSEL_LSB];
    wire [4:0] acq_len = acq_periods(acq_sel);
    wire [4:0] cnt_inc = cnt_r + 5'h01;
    // The divider realigns on the very edge that changes phase, so the
    // first bit period of every phase in a divider setting is whole instead of a leftover
    // fragment of the free-running count.
    wire restart_w = (st_nxt != st_r);

    // ======================================================================
    // Bus decode
    // ======================================================================
    // Every access gets exactly one wait state: its first cycle loads read
    // data into a register, so the bus never sees the decode mux directly.
    // Layout: timing 0x00, control 0x04, trigger enables 0x08, status 0x0C,
    // result 0x10. Unmapped reads give zero; writes there, or to the
    // read-only status and result words, are dropped.
    assign o_waitrequest = (i_read | i_write) & ~ack_r;
    assign o_readdata = rdata_r;
    wire wr_take = i_write & ack_r;
    wire wr_timing = wr_take && addr_hit(i_address, `REG_TIMING_CTRL);
    wire wr_ctrl = wr_take && addr_hit(i_address, `REG_CONV_CTRL);
    wire wr_trig = wr_take && addr_hit(i_address, `REG_TRIG_EN);

    always @(posedge i_clk) begin
        if (!i_resetn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (i_read | i_write) & ~ack_r;
        end
    end

    // Status shows only the go flag and enable: acquisition and conversion
    // read the same, so software cannot tell where one ends.
    always @* begin
        rdata_nxt = 32'h00000000;
        case (i_address)
            `REG_TIMING_CTRL: rdata_nxt[6:0] = timing_r;
            `REG_CONV_CTRL: begin
                rdata_nxt[`CTRL_GO_BIT] = go_r;
                rdata_nxt[`CTRL_ENABLE_BIT] = enable_r;
            end
            `REG_TRIG_EN: rdata_nxt[TRIG_W-1:0] = trig_en_r;
            `REG_STATUS: begin
                rdata_nxt[`STAT_GO_BIT] = go_r;
                rdata_nxt[`STAT_ENABLE_BIT] = enable_r;
            end
            `REG_RESULT: rdata_nxt[RES_W-1:0] = result_r;
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_resetn) begin
            rdata_r <= 32'h00000000;
        end else if (i_read & ~ack_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    // ======================================================================
    // Configuration registers
    // ======================================================================
    // Clearing enable also drops go on the next edge, which aborts any
    // acquisition or conversion in flight.
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            timing_r <= `TIMING_CTRL_RESET;
            enable_r <= `ENABLE_RESET;
            trig_en_r <= `TRIG_EN_RESET;
        end else begin
            if (wr_timing) begin
                timing_r <= i_writedata[6:0];
            end
            if (wr_ctrl) begin
                enable_r <= i_writedata[`CTRL_ENABLE_BIT];
            end
            if (wr_trig) begin
                trig_en_r <= i_writedata[TRIG_W-1:0];
            end
        end
    end

    // ======================================================================
    // Go flag
    // ======================================================================
    // Only enabled trigger sources count, and only while the converter is
    // enabled, so a stray pulse on a masked source never starts a cycle.
    wire hw_trig = enable_r && ((i_trigger & trig_en_r) != {TRIG_W{1'b0}});
    wire sw_go = wr_ctrl && i_writedata[`CTRL_GO_BIT] && i_writedata[`CTRL_ENABLE_BIT];
    wire sw_stop = wr_ctrl && !i_writedata[`CTRL_GO_BIT];
    wire conv_end = st_r[2] && tad_tick && period_done(cnt_r, `CONV_BIT_PERIODS);

    // A set arriving with the end of a conversion wins and starts a new one.
    always @* begin
        go_nxt = go_r;
        if (conv_end || sw_stop || !enable_r) begin
            go_nxt = 1'b0;
        end
        if (sw_go || hw_trig) begin
            go_nxt = 1'b1;
        end
    end

    always @(posedge i_clk) begin
        if (!i_resetn) begin
            go_r <= 1'b0;
        end else begin
            go_r <= go_nxt;
        end
    end

    // ======================================================================
    // Sequencer
    // ======================================================================
    // A zero acquisition code converts at once; software owns the sampling
    // time then. Dropping go in either active phase aborts back to idle on the next edge,
    // with no result or done pulse unless the last conversion tick falls in that cycle.
    always @* begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            ST_IDLE: begin
                cnt_nxt = 5'h00;
                if (go_r) begin
                    if (acq_len == 5'h00) begin
                        st_nxt = ST_CONV;
                    end else begin
                        st_nxt = ST_ACQ;
                    end
                end
            end
            ST_ACQ: begin
                if (!go_r) begin
                    st_nxt = ST_IDLE;
                end else if (tad_tick) begin
                    if (period_done(cnt_r, acq_len)) begin
                        st_nxt = ST_CONV;
                        cnt_nxt = 5'h00;
                    end else begin
                        cnt_nxt = cnt_inc;
                    end
                end
            end
            ST_CONV: begin
                if (!go_r) begin
                    st_nxt = ST_IDLE;
                end else if (tad_tick) begin
                    if (period_done(cnt_r, `CONV_BIT_PERIODS)) begin
                        st_nxt = ST_IDLE;
                        cnt_nxt = 5'h00;
                    end else begin
                        cnt_nxt = cnt_inc;
                    end
                end
            end
            default: begin
                st_nxt = ST_IDLE;
                cnt_nxt = 5'h00;
            end
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_resetn) begin
            st_r <= ST_IDLE;
            cnt_r <= 5'h00;
            o_conv_done <= 1'b0;
            result_r <= {RES_W{1'b0}};
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            o_conv_done <= conv_end;
            if (conv_end) begin
                result_r <= i_core_result;
            end
        end
    end

    // ======================================================================
    // Bit period source
    // ======================================================================
    // The RC source runs free and cannot be realigned, so in the RC modes
    // the first bit period of a phase may be short; only the divider
    // settings give a whole first period.
    bit_period_gen #(
        .CNT_W(6)
    ) u_bit_period_gen (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_restart(restart_w),
        .i_sel(clk_sel),
        .i_rc_tick(i_rc_tick),
        .o_tick(tad_tick)
    );

    // ======================================================================
    // Analog core side
    // ======================================================================
    // The switch follows the state flop, so the capacitor opens on the
    // same edge that starts the conversion count.
    assign o_hold_connect = ~st_r[2];
    assign o_conv_active = st_r[2];
    assign o_bit_tick = st_r[2] & tad_tick;
    assign o_result = result_r;

endmodule // adc_acq_ctrl

/* File: sim/adc_acq_ctrl_assertions.sv */
/* Port checker for adc_acq_ctrl, bound to every instance.
   Assumes a single clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module adc_acq_ctrl_assertions #(parameter TRIG_W = 5, parameter RES_W = 10) (
    input wire i_clk,
    input wire i_resetn,
    input wire [4:0] i_address,
    input wire i_read,
    input wire i_write,
    input wire [31:0] i_writedata,
    input wire [31:0] o_readdata,
    input wire o_waitrequest,
    input wire [TRIG_W-1:0] i_trigger,
    input wire i_rc_tick,
    input wire [RES_W-1:0] i_core_result,
    input wire o_hold_connect,
    input wire o_conv_active,
    input wire o_bit_tick,
    input wire o_conv_done,
    input wire [RES_W-1:0] o_result
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // =====================================================================
    // Bit period count of the running conversion
    // =====================================================================
    // The count holds after the conversion so the done pulse can see it.
    reg act_r;
    reg [4:0] tick_cnt_r;
    always @(posedge i_clk) begin
        act_r <= o_conv_active;
        if (!i_resetn) tick_cnt_r <= 5'h00;
        else if (o_conv_active && !act_r) tick_cnt_r <= {4'h0, o_bit_tick};
        else if (o_conv_active && o_bit_tick) tick_cnt_r <= tick_cnt_r + 5'h01;
    end
    property p_wait_one; (i_read || i_write) && o_waitrequest |=> !o_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("more than one wait state");
    property p_conv_disc; o_conv_active |-> !o_hold_connect; endproperty
    a_conv_disc: assert property (p_conv_disc) else $error("capacitor connected");
    property p_fall_conv; $fell(o_hold_connect) |-> o_conv_active; endproperty
    a_fall_conv: assert property (p_fall_conv) else $error("sampling ended early");
    property p_tick_conv; o_bit_tick |-> o_conv_active; endproperty
    a_tick_conv: assert property (p_tick_conv) else $error("tick outside conversion");
    property p_tick_gap; o_bit_tick |=> !o_bit_tick; endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("bit period below two");
    property p_first_whole; $rose(o_conv_active) |-> !o_bit_tick; endproperty
    a_first_whole: assert property (p_first_whole) else $error("short first period");
    property p_twelve; o_conv_done |-> tick_cnt_r == 5'h0C; endproperty
    a_twelve: assert property (p_twelve) else $error("conversion not twelve periods");
    property p_done_end; o_conv_done |-> $fell(o_conv_active); endproperty
    a_done_end: assert property (p_done_end) else $error("done not at end");
    property p_done_pulse; o_conv_done |=> !o_conv_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one");
    property p_result_cap; $changed(o_result) |-> o_conv_done; endproperty
    a_result_cap: assert property (p_result_cap) else $error("result changed early");
endmodule // adc_acq_ctrl_assertions
bind adc_acq_ctrl adc_acq_ctrl_assertions #(.TRIG_W(TRIG_W), .RES_W(RES_W)) u_chk (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_trigger(i_trigger), .i_rc_tick(i_rc_tick),
    .i_core_result(i_core_result), .o_hold_connect(o_hold_connect),
    .o_conv_active(o_conv_active), .o_bit_tick(o_bit_tick), .o_conv_done(o_conv_done),
    .o_result(o_result));

/* File: sim/analog_core_model.sv */
/* Behavioural sample-and-hold core with a free-running RC oscillator.
   Assumes the controller drives i_hold_connect from a flop on i_clk. */
`timescale 1ns/1ps
module analog_core_model #(parameter [3:0] RC_LAST = 4'h4) (
    input wire i_clk,
    input wire i_resetn,
    input wire i_hold_connect,
    output logic o_rc_tick,
    output logic [9:0] o_sample
);
    logic [3:0] rc_cnt_r;
    // =====================================================================
    // Oscillator and holding capacitor
    // =====================================================================
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            rc_cnt_r <= 4'h0;
            o_rc_tick <= 1'b0;
            o_sample <= 10'h155;
        end else begin
            rc_cnt_r <= (rc_cnt_r == RC_LAST) ? 4'h0 : rc_cnt_r + 4'h1;
            o_rc_tick <= (rc_cnt_r == RC_LAST);
            // The input moves every cycle, so a late disconnect shows up as a wrong code.
            if (i_hold_connect) o_sample <= o_sample + 10'h0B3;
        end
    end
endmodule // analog_core_model

/* File: sim/tb_top.sv */
/* Self-checking bench for adc_acq_ctrl with the analog core model.
   Assumes one wait state per bus access and a 5-cycle RC period. */
`timescale 1ns/1ps
module tb_top;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [4:0] i_address = 5'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [4:0] i_trigger = 5'h00;
    wire [31:0] o_readdata;
    wire o_waitrequest, rc_tick, o_hold_connect, o_conv_active, o_bit_tick, o_conv_done;
    wire [9:0] core_result, o_result;
    int bad_count = 0, total_checks = 0, cyc = 0, c0, seen;
    logic [31:0] rd;
    int per [8] = '{2, 8, 32, 20, 4, 16, 64, 5};
    always #25 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;
    adc_acq_ctrl u_adc_acq_ctrl (.i_clk(i_clk), .i_resetn(i_resetn), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_trigger(i_trigger),
        .i_rc_tick(rc_tick), .i_core_result(core_result), .o_hold_connect(o_hold_connect),
        .o_conv_active(o_conv_active), .o_bit_tick(o_bit_tick),
        .o_conv_done(o_conv_done), .o_result(o_result));
    analog_core_model u_analog_core_model (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_hold_connect(o_hold_connect), .o_rc_tick(rc_tick), .o_sample(core_result));
    // =====================================================================
    // Tasks
    // =====================================================================
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        i_address <= a;
        i_writedata <= d;
        i_read <= !wr;
        i_write <= wr;
        @(posedge i_clk iff !o_waitrequest);
        rd = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic watch(input int p, input int acq, input int s0);
        int n, gap, last, g;
        logic [9:0] smp;
        n = 0; gap = 0; last = 0; g = 0;
        while (!o_conv_active && g < 3000) begin @(negedge i_clk); g++; end
        if (acq == 0) chk(cyc - s0 <= 3, 1);
        else chk(cyc - s0 >= 2*acq*p && cyc - s0 <= 2*acq*p + 4, 1);
        smp = core_result;
        while (!o_conv_done && g < 3000) begin
            if (o_bit_tick) begin
                if (n > 0) chk(cyc - last, p);
                gap = cyc - last;
                last = cyc;
                n++;
            end
            @(negedge i_clk);
            g++;
        end
        chk(g < 3000, 1);
        chk(n, 12);
        chk(gap, p);
        chk(o_result, smp);
        @(posedge i_clk);
    endtask
    task automatic pulse(input logic [4:0] t);
        i_trigger <= t;
        @(posedge i_clk);
        i_trigger <= 5'h00;
        c0 = cyc;
    endtask
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // =====================================================================
    // Scenarios
    // =====================================================================
    initial begin
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        for (int a = 0; a < 6; a++) begin bus(0, 5'(a * 4), 0); chk(rd, 0); end
        bus(1, 5'h00, 32'hFFFFFFFF);
        bus(0, 5'h00, 0); chk(rd, 32'h7F);
        bus(1, 5'h14, 32'h1);
        bus(1, 5'h0C, 32'h3);
        bus(0, 5'h0C, 0); chk(rd, 0);
        for (int s = 0; s < 8; s++) begin
            bus(1, 5'h00, s);
            bus(1, 5'h04, 32'h3);
            watch(per[s], 0, cyc);
        end
        bus(1, 5'h00, 32'h10);
        bus(1, 5'h04, 32'h3);
        watch(2, 2, cyc);
        bus(1, 5'h08, 32'h1);
        bus(1, 5'h00, 32'h15);
        bus(1, 5'h04, 32'h2);
        pulse(5'h02);
        repeat (40) @(posedge i_clk);
        bus(0, 5'h0C, 0); chk(rd, 32'h2);
        pulse(5'h01);
        bus(0, 5'h0C, 0); chk(rd, 32'h3);
        watch(16, 2, c0);
        bus(0, 5'h0C, 0); chk(rd, 32'h2);
        bus(1, 5'h00, 32'h6);
        bus(1, 5'h04, 32'h3);
        repeat (100) @(posedge i_clk);
        bus(1, 5'h04, 32'h2);
        seen = 0;
        repeat (900) @(negedge i_clk) if (o_conv_done || o_conv_active) seen = 1;
        chk(seen, 0);
        end_of_test;
    end
    initial begin
        #1_000_000;
        bad_count++;
        end_of_test;
    end
endmodule // tb_top
